// ### inc/ddr_port_pkg.sv
// Shared constants, types and word helpers for the four-lane DDR parallel port
`default_nettype none
package ddr_port_pkg;
    localparam int LANES = 4;
    localparam int WORD_W = 10;
    localparam int DATA_W = 8;
    localparam int KFLAG_BIT = 8;
    localparam int ERR_BIT = 9;
    localparam int LANE_A = 0;
    localparam int CLK_PERIOD_NS = 10;
    localparam int LINK_HALF_NS = 40;
    // Half link period, rounded down so the link never runs slower than specified
    localparam int LINK_HALF_CYC = LINK_HALF_NS / CLK_PERIOD_NS;
    // Data moves midway between clock edges to give the far end setup and hold
    localparam int DATA_SLOT_CYC = LINK_HALF_CYC / 2;
    localparam int CNT_W = 3;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(LINK_HALF_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_DATA = CNT_W'(DATA_SLOT_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_RESET = 3'h0;
    localparam int FIFO_DEPTH = 4;
    localparam int RX_ENTRY_W = WORD_W + 2;
    localparam logic [WORD_W-1:0] IDLE_WORD = 10'h000;
    localparam logic [WORD_W-1:0] WORD_RESET = 10'h000;

    typedef logic [WORD_W-1:0] word_t;
    typedef logic [LANES-1:0][WORD_W-1:0] lane_words_t;

    // Transmit view: in codec mode bit 9 carries no meaning and is forced low
    function automatic word_t tx_view(input logic codecOn, input word_t raw);
        tx_view = codecOn ? {1'b0, raw[KFLAG_BIT], raw[DATA_W-1:0]} : raw;
    endfunction

    // Receive view: raw character, or byte with K flag on bit 8 and error on bit 9
    function automatic word_t rx_view(input logic codecOn,
                                      input logic [RX_ENTRY_W-1:0] entry);
        rx_view = codecOn ? {entry[WORD_W+1], entry[WORD_W], entry[DATA_W-1:0]}
                          : entry[WORD_W-1:0];
    endfunction
endpackage
`default_nettype wire

// ### inc/ddr_port_if.sv
// Pin-level carrier between the transceiver end and the controller end
`default_nettype none
interface ddr_port_if;
    logic [ddr_port_pkg::LANES-1:0] txClk;
    ddr_port_pkg::lane_words_t txWord;
    logic [ddr_port_pkg::LANES-1:0] rxClk;
    ddr_port_pkg::lane_words_t rxWord;
    logic laneSyncEnable;
    logic codecEnablePin;

    modport device (
        input txClk,
        input txWord,
        input laneSyncEnable,
        input codecEnablePin,
        output rxClk,
        output rxWord
    );
    modport ctrl (
        output txClk,
        output txWord,
        output laneSyncEnable,
        output codecEnablePin,
        input rxClk,
        input rxWord
    );
endinterface
`default_nettype wire

// ### core/word_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`default_nettype none
module word_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wrPtr_q;
    logic [PTR_W-1:0] rdPtr_q;
    logic [CNT_W-1:0] count_q;

    wire push = inValid && inReady;
    wire pop = outValid && outReady;
    wire wrWrap = (wrPtr_q == PTR_W'(DEPTH - 1));
    wire rdWrap = (rdPtr_q == PTR_W'(DEPTH - 1));

    assign inReady = (count_q != CNT_W'(DEPTH));
    assign outValid = (count_q != '0);
    assign outData = mem[rdPtr_q];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wrPtr_q <= wrWrap ? '0 : wrPtr_q + PTR_W'(1);
            end
            if (pop) begin
                rdPtr_q <= rdWrap ? '0 : rdPtr_q + PTR_W'(1);
            end
            if (push && !pop) begin
                count_q <= count_q + CNT_W'(1);
            end else if (pop && !push) begin
                count_q <= count_q - CNT_W'(1);
            end
        end
    end
endmodule // word_fifo
`default_nettype wire

// ### core/lane_device_end.sv
// Transceiver end of the four-lane DDR parallel port
`default_nettype none
module lane_device_end (
    input wire logic clk,
    input wire logic sys_rst,
    ddr_port_if.device link,
    input wire logic codecEnableCfg,
    input wire ddr_port_pkg::lane_words_t rxUserWord,
    input wire logic [ddr_port_pkg::LANES-1:0] rxUserK,
    input wire logic [ddr_port_pkg::LANES-1:0] rxUserErr,
    input wire logic [ddr_port_pkg::LANES-1:0] rxUserValid,
    output logic [ddr_port_pkg::LANES-1:0] rxUserReady,
    output ddr_port_pkg::lane_words_t txUserWord,
    output logic [ddr_port_pkg::LANES-1:0] txUserValid,
    output logic codecActive,
    output logic laneSyncActive
);
    localparam int L = ddr_port_pkg::LANES;
    localparam int EW = ddr_port_pkg::RX_ENTRY_W;

    // Pin synchronisers; first stages feed only second stages
    logic [L-1:0] txClkS1_q;
    logic [L-1:0] txClkS2_q;
    logic [L-1:0] txClkS3_q;
    ddr_port_pkg::lane_words_t txWordS1_q;
    ddr_port_pkg::lane_words_t txWordS2_q;
    logic laneSyncS1_q;
    logic laneSyncS2_q;
    logic codecPinS1_q;
    logic codecPinS2_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            txClkS1_q <= '0;
            txClkS2_q <= '0;
            txClkS3_q <= '0;
            txWordS1_q <= '0;
            txWordS2_q <= '0;
            laneSyncS1_q <= 1'b0;
            laneSyncS2_q <= 1'b0;
            codecPinS1_q <= 1'b0;
            codecPinS2_q <= 1'b0;
        end else begin
            txClkS1_q <= link.txClk;
            txClkS2_q <= txClkS1_q;
            txClkS3_q <= txClkS2_q;
            txWordS1_q <= link.txWord;
            txWordS2_q <= txWordS1_q;
            laneSyncS1_q <= link.laneSyncEnable;
            laneSyncS2_q <= laneSyncS1_q;
            codecPinS1_q <= link.codecEnablePin;
            codecPinS2_q <= codecPinS1_q;
        end
    end

    // Clock and data share the same two-stage delay, so their alignment is kept
    wire [L-1:0] txEdge = txClkS2_q ^ txClkS3_q;
    wire codecOn = codecPinS2_q && codecEnableCfg;
    wire syncOn = laneSyncS2_q;

    // Transmit capture: lane A always on its own clock, others selectable
    logic [L-1:0] capEdge;
    ddr_port_pkg::lane_words_t capWord;

    always_comb begin
        for (int i = 0; i < L; i++) begin
            capEdge[i] = (syncOn && i != ddr_port_pkg::LANE_A)
                       ? txEdge[ddr_port_pkg::LANE_A]
                       : txEdge[i];
            // Raw ten bits in codec-off mode, byte plus K request otherwise
            capWord[i] = ddr_port_pkg::tx_view(codecOn, txWordS2_q[i]);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            txUserWord <= '0;
            txUserValid <= '0;
        end else begin
            txUserValid <= capEdge;
            for (int i = 0; i < L; i++) begin
                if (capEdge[i]) begin
                    txUserWord[i] <= capWord[i];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            codecActive <= 1'b0;
            laneSyncActive <= 1'b0;
        end else begin
            codecActive <= codecOn;
            laneSyncActive <= syncOn;
        end
    end

    // Receive clock: one divider serves every lane, so lanes stay edge aligned
    logic [ddr_port_pkg::CNT_W-1:0] divCnt_q;
    logic rxGen_q;

    wire divLast = (divCnt_q == ddr_port_pkg::CNT_LAST);
    wire dataSlot = (divCnt_q == ddr_port_pkg::CNT_DATA);
    wire rxGen_d = divLast ? ~rxGen_q : rxGen_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            divCnt_q <= ddr_port_pkg::CNT_RESET;
            rxGen_q <= 1'b0;
        end else begin
            divCnt_q <= divLast ? ddr_port_pkg::CNT_RESET
                                : divCnt_q + ddr_port_pkg::CNT_W'(1);
            rxGen_q <= rxGen_d;
        end
    end

    // Lanes B-D clocks are parked low under sync; the far end must use lane A
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            link.rxClk <= '0;
        end else begin
            for (int i = 0; i < L; i++) begin
                link.rxClk[i] <= (syncOn && i != ddr_port_pkg::LANE_A)
                               ? 1'b0 : rxGen_d;
            end
        end
    end

    // Receive buffering: user pushes, each link half period pops one word
    logic [L-1:0] fifoOutValid;
    logic [L-1:0][EW-1:0] fifoOutData;

    for (genvar g = 0; g < L; g++) begin : g_rx_fifo
        word_fifo #(
            .WIDTH(EW),
            .DEPTH(ddr_port_pkg::FIFO_DEPTH)
        ) u_fifo (
            .clk(clk),
            .sys_rst(sys_rst),
            .inData({rxUserErr[g], rxUserK[g], rxUserWord[g]}),
            .inValid(rxUserValid[g]),
            .inReady(rxUserReady[g]),
            .outData(fifoOutData[g]),
            .outValid(fifoOutValid[g]),
            .outReady(dataSlot)
        );
    end

    // One word per receive edge; an empty buffer sends the idle word
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            link.rxWord <= '0;
        end else if (dataSlot) begin
            for (int i = 0; i < L; i++) begin
                link.rxWord[i] <= fifoOutValid[i]
                    ? ddr_port_pkg::rx_view(codecOn, fifoOutData[i])
                    : ddr_port_pkg::IDLE_WORD;
            end
        end
    end
endmodule // lane_device_end
`default_nettype wire

// ### core/lane_ctrl_end.sv
// Controller end of the four-lane DDR parallel port
`default_nettype none
module lane_ctrl_end (
    input wire logic clk,
    input wire logic sys_rst,
    ddr_port_if.ctrl link,
    input wire logic laneSyncReq,
    input wire logic codecPinReq,
    input wire ddr_port_pkg::lane_words_t txUserWord,
    output logic [ddr_port_pkg::LANES-1:0] txUserTake,
    output ddr_port_pkg::lane_words_t rxUserWord,
    output logic [ddr_port_pkg::LANES-1:0] rxUserValid
);
    localparam int L = ddr_port_pkg::LANES;

    // Transmit clock divider, shared by all lanes so they stay aligned to lane A
    logic [ddr_port_pkg::CNT_W-1:0] divCnt_q;
    logic txGen_q;

    wire divLast = (divCnt_q == ddr_port_pkg::CNT_LAST);
    wire dataSlot = (divCnt_q == ddr_port_pkg::CNT_DATA);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            divCnt_q <= ddr_port_pkg::CNT_RESET;
            txGen_q <= 1'b0;
            link.txClk <= '0;
            link.txWord <= '0;
            link.laneSyncEnable <= 1'b0;
            link.codecEnablePin <= 1'b0;
            txUserTake <= '0;
        end else begin
            divCnt_q <= divLast ? ddr_port_pkg::CNT_RESET
                                : divCnt_q + ddr_port_pkg::CNT_W'(1);
            txGen_q <= divLast ? ~txGen_q : txGen_q;
            link.txClk <= {L{divLast ? ~txGen_q : txGen_q}};
            link.laneSyncEnable <= laneSyncReq;
            link.codecEnablePin <= codecPinReq;
            // A fresh word per half period, one for each edge
            txUserTake <= {L{dataSlot}};
            if (dataSlot) begin
                link.txWord <= txUserWord;
            end
        end
    end

    // Receive side: synchronise pins, pick lane A clock under sync
    logic [L-1:0] rxClkS1_q;
    logic [L-1:0] rxClkS2_q;
    logic [L-1:0] rxClkS3_q;
    ddr_port_pkg::lane_words_t rxWordS1_q;
    ddr_port_pkg::lane_words_t rxWordS2_q;
    logic syncUsed_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rxClkS1_q <= '0;
            rxClkS2_q <= '0;
            rxClkS3_q <= '0;
            rxWordS1_q <= '0;
            rxWordS2_q <= '0;
            syncUsed_q <= 1'b0;
        end else begin
            rxClkS1_q <= link.rxClk;
            rxClkS2_q <= rxClkS1_q;
            rxClkS3_q <= rxClkS2_q;
            rxWordS1_q <= link.rxWord;
            rxWordS2_q <= rxWordS1_q;
            syncUsed_q <= laneSyncReq;
        end
    end

    wire [L-1:0] rxEdge = rxClkS2_q ^ rxClkS3_q;
    logic [L-1:0] selEdge;

    always_comb begin
        for (int i = 0; i < L; i++) begin
            selEdge[i] = (syncUsed_q && i != ddr_port_pkg::LANE_A)
                       ? rxEdge[ddr_port_pkg::LANE_A] : rxEdge[i];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rxUserWord <= '0;
            rxUserValid <= '0;
        end else begin
            rxUserValid <= selEdge;
            for (int i = 0; i < L; i++) begin
                if (selEdge[i]) begin
                    rxUserWord[i] <= rxWordS2_q[i];
                end
            end
        end
    end
endmodule // lane_ctrl_end
`default_nettype wire

// ### bench/ddr_port_monitor.sv
// Concurrent checks on the link between the two port ends
`default_nettype none
module ddr_port_monitor (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] txClk,
    input wire ddr_port_pkg::lane_words_t txWord,
    input wire logic [3:0] rxClk,
    input wire ddr_port_pkg::lane_words_t rxWord,
    input wire logic laneSyncEnable,
    input wire logic codecEnablePin
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_txclk_half_period: assert property (
        $changed(txClk[0]) |=> $stable(txClk[0])[*3] ##1 $changed(txClk[0]))
        else $error("transmit clock half period wrong");
    a_txword_mid_slot: assert property (
        $changed(txWord[0]) |-> !$changed(txClk[0]) ##2 $changed(txClk[0]))
        else $error("transmit word not centred on clock");
    a_txword_hold: assert property (
        $changed(txClk[0]) |-> $stable(txWord[0]) ##1 $stable(txWord[0]))
        else $error("transmit word moved at clock edge");
    a_tx_own_clock: assert property (
        !laneSyncEnable && $changed(txWord[1]) |-> ##2 $changed(txClk[1]))
        else $error("lane B word not timed on its own clock");
    a_tx_sync_align: assert property (
        laneSyncEnable && $changed(txWord[2]) |-> ##2 $changed(txClk[0]))
        else $error("lane C word not aligned to lane A clock");
    a_rxclk_half_period: assert property (
        $changed(rxClk[0]) |=> $stable(rxClk[0])[*3] ##1 $changed(rxClk[0]))
        else $error("receive clock half period wrong");
    a_rxword_mid_slot: assert property (
        $changed(rxWord[0]) |-> !$changed(rxClk[0]) ##2 $changed(rxClk[0]))
        else $error("receive word not centred on clock");
    a_rx_sync_timing: assert property (
        laneSyncEnable[*8] ##0 $changed(rxWord[2]) |-> ##2 $changed(rxClk[0]))
        else $error("lane C receive word not on lane A clock");
    a_sync_clocks_low: assert property (
        laneSyncEnable[*8] |-> rxClk[3:1] == 3'h0)
        else $error("lanes B to D receive clocks active under sync");
    cover property (laneSyncEnable && $changed(rxWord[2]));
    cover property (codecEnablePin && $changed(txWord[3]));
    cover property (!laneSyncEnable && $changed(rxWord[0]));
endmodule // ddr_port_monitor
`default_nettype wire

// ### bench/quad_lane_ddr_parallel_port_test.sv
// Self-checking bench joining the device end and the controller end
`default_nettype none
module quad_lane_ddr_parallel_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk;
    logic sys_rst;
    logic codecEnableCfg;
    logic laneSyncReq;
    logic codecPinReq;
    ddr_port_pkg::lane_words_t devRxWord;
    logic [3:0] devRxK;
    logic [3:0] devRxErr;
    logic [3:0] devRxValid;
    logic [3:0] devRxReady;
    ddr_port_pkg::lane_words_t devTxWord;
    logic [3:0] devTxValid;
    logic codecActive;
    logic laneSyncActive;
    ddr_port_pkg::lane_words_t ctlTxWord;
    logic [3:0] ctlTxTake;
    ddr_port_pkg::lane_words_t ctlRxWord;
    logic [3:0] ctlRxValid;
    int n_fail;
    int total_checks;

    ddr_port_if link ();
    lane_device_end lane_device_end_i (.clk(clk), .sys_rst(sys_rst), .link(link),
        .codecEnableCfg(codecEnableCfg), .rxUserWord(devRxWord), .rxUserK(devRxK),
        .rxUserErr(devRxErr), .rxUserValid(devRxValid), .rxUserReady(devRxReady),
        .txUserWord(devTxWord), .txUserValid(devTxValid), .codecActive(codecActive),
        .laneSyncActive(laneSyncActive));
    lane_ctrl_end lane_ctrl_end_i (.clk(clk), .sys_rst(sys_rst), .link(link),
        .laneSyncReq(laneSyncReq), .codecPinReq(codecPinReq), .txUserWord(ctlTxWord),
        .txUserTake(ctlTxTake), .rxUserWord(ctlRxWord), .rxUserValid(ctlRxValid));
    ddr_port_monitor ddr_port_monitor_i (.clk(clk), .sys_rst(sys_rst), .txClk(link.txClk),
        .txWord(link.txWord), .rxClk(link.rxClk), .rxWord(link.rxWord),
        .laneSyncEnable(link.laneSyncEnable), .codecEnablePin(link.codecEnablePin));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    function automatic logic hit(input int sel, input int lane);
        case (sel)
            0: hit = ctlTxTake[lane] === 1'b1;
            1: hit = devTxValid[lane] === 1'b1;
            default: hit = ctlRxValid[lane] === 1'b1 && ctlRxWord[lane] !== 10'h000;
        endcase
    endfunction

    // Pulses are sampled on the falling edge, clear of the launching edge
    task automatic await(input int sel, input int lane);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (!hit(sel, lane) && n < 200);
        if (n >= 200) check("handshake wait", 10'h001, 10'h000);
    endtask

    // Four takes first, so pin changes and the new word have crossed
    task automatic tx_case(input logic [9:0] w, input logic codec);
        logic [9:0] exp;
        @(posedge clk);
        for (int l = 0; l < 4; l++) ctlTxWord[l] <= w ^ 10'(l);
        repeat (4) await(0, 0);
        for (int l = 0; l < 4; l++) begin
            exp = codec ? ((w ^ 10'(l)) & 10'h1FF) : (w ^ 10'(l));
            repeat (2) begin
                await(1, l);
                check("txUserWord", devTxWord[l], exp);
            end
        end
    endtask

    // Eight back-to-back pushes outrun the drain, so the buffer must refuse
    task automatic rx_case(input int lane, input logic codec, input logic [9:0] w);
        logic sawFull;
        logic [9:0] v;
        sawFull = 1'b0;
        fork
        begin
            for (int i = 0; i < 8; i++) begin
                @(posedge clk);
                devRxValid[lane] <= 1'b1;
                devRxWord[lane] <= w + 10'(i);
                devRxK[lane] <= i[0];
                devRxErr[lane] <= i[1];
                @(negedge clk);
                for (int t = 0; devRxReady[lane] !== 1'b1 && t < 50; t++) begin
                    sawFull = 1'b1;
                    @(negedge clk);
                end
            end
            // The last word is only taken at this edge, so valid drops here
            @(posedge clk);
            devRxValid[lane] <= 1'b0;
        end
        begin
            for (int i = 0; i < 8; i++) begin
                v = w + 10'(i);
                await(2, lane);
                check("rxUserWord", ctlRxWord[lane],
                    codec ? {i[1], i[0], v[7:0]} : v);
            end
        end
        join
        @(posedge clk);
        check("rx buffer refused", 10'(sawFull), 10'h001);
        @(negedge clk);
        check("rx buffer drained", 10'(devRxReady[lane]), 10'h001);
    endtask

    // Whole run is under a thousand cycles; this leaves wide margin
    initial begin
        #400us;
        n_fail++;
        complete_run();
    end

    initial begin
        n_fail = 0;
        total_checks = 0;
        sys_rst = 1'b1;
        codecEnableCfg = 1'b0;
        laneSyncReq = 1'b0;
        codecPinReq = 1'b0;
        devRxWord = '0;
        devRxK = 4'h0;
        devRxErr = 4'h0;
        devRxValid = 4'h0;
        ctlTxWord = '0;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        for (int m = 0; m < 4; m++) begin
            @(posedge clk);
            codecPinReq <= m[1];
            codecEnableCfg <= m[0];
            tx_case(10'h3C5, m == 3);
            tx_case(10'h27A, m == 3);
            check("codecActive", 10'(codecActive), 10'(m == 3));
            rx_case(m, m == 3, 10'h2A1);
            $display("test codec mode %0d done", m);
        end
        @(posedge clk);
        laneSyncReq <= 1'b1;
        tx_case(10'h1E3, 1'b1);
        check("laneSyncActive", 10'(laneSyncActive), 10'h001);
        rx_case(2, 1'b1, 10'h181);
        $display("test lane sync done");
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        laneSyncReq <= 1'b0;
        tx_case(10'h0F3, 1'b1);
        $display("test reset in mid-run done");
        complete_run();
    end
endmodule // quad_lane_ddr_parallel_port_test
`default_nettype wire
